// ===== dspb_map.svh
`ifndef DSPB_MAP_SVH
`define DSPB_MAP_SVH

// ----------------------------------------
// Parameter numbers
// ----------------------------------------
`define DSPB_PAR_STATUS  8'h01
`define DSPB_PAR_SPEED   8'h02
`define DSPB_PAR_POS     8'h03
`define DSPB_PAR_TORQUE  8'h04
`define DSPB_PAR_PEAK    8'h05
`define DSPB_PAR_ULOGIC  8'h06
`define DSPB_PAR_UMOTOR  8'h07
`define DSPB_PAR_TEMP    8'h08
`define DSPB_PAR_NODE    8'h09
`define DSPB_PAR_DATE    8'h0A
`define DSPB_PAR_SERIAL  8'h0B

// ----------------------------------------
// Widths, reset values, step, skip code and bit positions
// ----------------------------------------
`define DSPB_PAR_W       8
`define DSPB_WORD_W      16
`define DSPB_DATA_W      32
`define DSPB_CTRL_SKIP   8'h00
`define DSPB_ZERO16      16'h0000
`define DSPB_ZERO32      32'h0000_0000
`define DSPB_POS_RESET   32'h0000_0000
`define DSPB_POS_STEP    32'h0000_0001
`define DSPB_RUN_BIT     6
`define DSPB_SIGN_BIT    15
`endif

// ===== dspb_pkg.sv
`include "dspb_map.svh"
package dspb_pkg;
  // Answer sequencer states, one-hot
  typedef enum logic [1:0] {
    DSPB_IDLE  = 2'b01,
    DSPB_REPLY = 2'b10
  } dspb_state_t;

  typedef logic [15:0]        dspb_word_t;
  typedef logic signed [31:0] dspb_pos_t;

  // True for every parameter number that the bank holds
  function automatic logic dspb_par_known(input logic [7:0] par);
    dspb_par_known = (par >= `DSPB_PAR_STATUS) && (par <= `DSPB_PAR_SERIAL);
  endfunction
endpackage

// ===== dspb_pos_counter.sv
`timescale 1ns/100ps
`include "dspb_map.svh"
module dspb_pos_counter
  import dspb_pkg::*;
(
  input  wire logic      ref_clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      step_in,
  input  wire logic      dir_in,
  input  wire logic      load_in,
  input  wire dspb_pos_t load_value_in,
  output dspb_pos_t      position_out
);
  // ----------------------------------------
  // Position accumulator
  // ----------------------------------------
  // A reload wins over a step in the same cycle: the written value is exact
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      position_out <= `DSPB_POS_RESET;
    end else if (load_in) begin
      position_out <= load_value_in;
    end else if (step_in) begin
      position_out <= dir_in ? position_out + `DSPB_POS_STEP
                             : position_out - `DSPB_POS_STEP;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reload_exact_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    load_in |=> position_out == $past(load_value_in))
    else $error("position not reloaded with written value");
  hold_still_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!load_in && !step_in) |=> $stable(position_out))
    else $error("position moved without step or reload");
endmodule

// ===== dspb_peak_capture.sv
`timescale 1ns/100ps
`include "dspb_map.svh"
module dspb_peak_capture
  import dspb_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       running_in,
  input  wire logic       startup_in,
  input  wire logic       braking_in,
  input  wire dspb_word_t torque_in,
  output dspb_word_t      peak_out
);
  logic running_q;

  // Run edge tracker
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      running_q <= 1'b0;
    end else begin
      running_q <= running_in;
    end
  end

  // ----------------------------------------
  // Peak hold, cleared at the start of each run
  // ----------------------------------------
  // Value survives the end of a run so it can be read at standstill
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      peak_out <= `DSPB_ZERO16;
    end else if (running_in && !running_q) begin
      peak_out <= `DSPB_ZERO16;
    end else if (running_in && !startup_in && !braking_in && torque_in > peak_out) begin
      peak_out <= torque_in;
    end
  end

  excluded_phase_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (running_q && (startup_in || braking_in || !running_in)) |=> $stable(peak_out))
    else $error("peak changed outside the measured phase");
  peak_tracks_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (running_q && running_in && !startup_in && !braking_in)
      |=> peak_out >= $past(torque_in) && peak_out >= $past(peak_out))
    else $error("peak missed a larger torque");
endmodule

// ===== dspb_top.sv
`timescale 1ns/100ps
`include "dspb_map.svh"
module dspb_top
  import dspb_pkg::*;
#(
  parameter logic [15:0] MFG_YEAR_WEEK = 16'h0000, // Arbitrary value, set per unit
  parameter logic [15:0] UNIT_SERIAL   = 16'h0000  // Arbitrary value, set per unit
)(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Parameter channel request
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [7:0]  req_par_in,
  input  wire logic [7:0]  req_ctrl_in,
  input  wire logic [31:0] req_wdata_in,
  // Parameter channel answer
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output logic             rsp_error_out,
  output logic [31:0]      rsp_data_out,
  // Status flags from the motion core, low byte
  input  wire logic        target_reached_in,
  input  wire logic        drag_error_in,
  input  wire logic        jog_reverse_key_in,
  input  wire logic        jog_forward_key_in,
  input  wire logic        motor_power_in,
  input  wire logic        run_aborted_in,
  input  wire logic        drive_running_in,
  input  wire logic        over_temperature_in,
  // Status flags from the motion core, high byte
  input  wire logic        against_loop_in,
  input  wire logic        general_error_in,
  input  wire logic        blocked_error_in,
  input  wire logic        manual_displaced_in,
  input  wire logic        bad_target_in,
  input  wire logic        motor_power_lost_in,
  input  wire logic        positive_limit_in,
  input  wire logic        negative_limit_in,
  // Measurements
  input  wire dspb_word_t  speed_in,
  input  wire dspb_word_t  torque_in,
  input  wire dspb_word_t  logic_volt_in,
  input  wire dspb_word_t  motor_volt_in,
  input  wire dspb_word_t  temperature_in,
  input  wire dspb_word_t  node_selector_in,
  // Motion phase and position steps
  input  wire logic        startup_phase_in,
  input  wire logic        braking_phase_in,
  input  wire logic        pos_step_in,
  input  wire logic        pos_dir_in
);
  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  dspb_state_t state;
  dspb_state_t next_state;
  dspb_word_t  drive_status_flags;
  dspb_word_t  speed_readback;
  dspb_word_t  torque_readback;
  dspb_word_t  logic_supply_voltage;
  dspb_word_t  motor_supply_voltage;
  dspb_word_t  internal_temperature;
  dspb_word_t  node_selector_setting;
  dspb_word_t  peak_torque_last_run;
  dspb_pos_t   position_readback;
  logic        accept;
  logic        pos_load;
  logic        next_error;
  logic [31:0] next_data;

  // Request is taken only while the sequencer is idle and ready is shown; ready
  // stays low for the first cycle after reset, so a request there is ignored
  assign accept = req_valid_in && req_ready_out && (state == DSPB_IDLE);

  // ----------------------------------------
  // Answer word helpers
  // ----------------------------------------
  // Kept as functions because every read answer except the position needs one of the two
  // Unsigned parameters fill the upper half of the answer with zeros
  function automatic logic [31:0] dspb_zext(input dspb_word_t value);
    dspb_zext = {`DSPB_ZERO16, value};
  endfunction

  // Signed parameters repeat their sign bit into the upper half
  function automatic logic [31:0] dspb_sext(input dspb_word_t value);
    dspb_sext = {{`DSPB_WORD_W{value[`DSPB_SIGN_BIT]}}, value};
  endfunction

  // ----------------------------------------
  // Status word and measurement snapshots
  // ----------------------------------------
  // Registered each cycle so a read sees one coherent sample of all flags
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      drive_status_flags <= `DSPB_ZERO16;
    end else begin
      drive_status_flags <= {negative_limit_in, positive_limit_in,
                             motor_power_lost_in, bad_target_in,
                             manual_displaced_in, blocked_error_in,
                             general_error_in, against_loop_in,
                             over_temperature_in, drive_running_in,
                             run_aborted_in, motor_power_in,
                             jog_forward_key_in, jog_reverse_key_in,
                             drag_error_in, target_reached_in};
    end
  end

  // Measurement samples, one cycle behind the converters
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      speed_readback        <= `DSPB_ZERO16;
      torque_readback       <= `DSPB_ZERO16;
      logic_supply_voltage  <= `DSPB_ZERO16;
      motor_supply_voltage  <= `DSPB_ZERO16;
      internal_temperature  <= `DSPB_ZERO16;
      node_selector_setting <= `DSPB_ZERO16;
    end else begin
      speed_readback        <= speed_in;
      torque_readback       <= torque_in;
      logic_supply_voltage  <= logic_volt_in;
      motor_supply_voltage  <= motor_volt_in;
      internal_temperature  <= temperature_in;
      node_selector_setting <= node_selector_in;
    end
  end

  // ----------------------------------------
  // Position and peak torque keepers
  // ----------------------------------------
  dspb_pos_counter u_pos (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .step_in       (pos_step_in),
    .dir_in        (pos_dir_in),
    .load_in       (pos_load),
    .load_value_in (req_wdata_in),
    .position_out  (position_readback)
  );

  dspb_peak_capture u_peak (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .running_in (drive_running_in),
    .startup_in (startup_phase_in),
    .braking_in (braking_phase_in),
    .torque_in  (torque_in),
    .peak_out   (peak_torque_last_run)
  );

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  // Standstill is judged from the registered running flag, the same
  // value a concurrent status read would return
  always_comb begin
    next_data  = `DSPB_ZERO32;
    next_error = 1'b0;
    pos_load   = 1'b0;
    if (!req_write_in) begin
      case (req_par_in)
        `DSPB_PAR_STATUS: next_data = dspb_zext(drive_status_flags);
        `DSPB_PAR_SPEED:  next_data = dspb_sext(speed_readback);
        `DSPB_PAR_POS:    next_data = position_readback;
        `DSPB_PAR_TORQUE: next_data = dspb_zext(torque_readback);
        `DSPB_PAR_PEAK:   next_data = dspb_zext(peak_torque_last_run);
        `DSPB_PAR_ULOGIC: next_data = dspb_zext(logic_supply_voltage);
        `DSPB_PAR_UMOTOR: next_data = dspb_zext(motor_supply_voltage);
        `DSPB_PAR_TEMP:   next_data = dspb_sext(internal_temperature);
        `DSPB_PAR_NODE:   next_data = dspb_zext(node_selector_setting);
        `DSPB_PAR_DATE:   next_data = dspb_zext(MFG_YEAR_WEEK);
        `DSPB_PAR_SERIAL: next_data = dspb_zext(UNIT_SERIAL);
        default:          next_error = 1'b1;
      endcase
    end else if (!dspb_par_known(req_par_in)) begin
      next_error = 1'b1;
    end else if (req_ctrl_in == `DSPB_CTRL_SKIP) begin
      // Control byte zero: the write is dropped on purpose, no error
      next_error = 1'b0;
    end else if (req_par_in != `DSPB_PAR_POS) begin
      next_error = 1'b1;
    end else if (drive_status_flags[`DSPB_RUN_BIT]) begin
      next_error = 1'b1;
    end else begin
      pos_load = accept;
    end
  end

  // ----------------------------------------
  // Answer sequencer
  // ----------------------------------------
  always_comb begin
    case (state)
      DSPB_IDLE:  next_state = accept ? DSPB_REPLY : DSPB_IDLE;
      DSPB_REPLY: next_state = DSPB_IDLE;
      default:    next_state = DSPB_IDLE;
    endcase
  end

  // Sequencer state and ready flag
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state         <= DSPB_IDLE;
      req_ready_out <= 1'b0;
    end else begin
      state         <= next_state;
      req_ready_out <= (next_state == DSPB_IDLE);
    end
  end

  // Answer registers; data and error stand until the next accepted request
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_error_out <= 1'b0;
      rsp_data_out  <= `DSPB_ZERO32;
    end else begin
      rsp_valid_out <= accept;
      if (accept) begin
        rsp_error_out <= next_error;
        rsp_data_out  <= next_data;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // All checks live in the one clock domain and are silenced during reset
  default clocking dspb_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Request classes used by several checks
  logic rd_status;
  logic wr_pos;
  logic wr_ro;
  assign rd_status = accept && !req_write_in && req_par_in == `DSPB_PAR_STATUS;
  assign wr_pos    = accept && req_write_in && req_par_in == `DSPB_PAR_POS
                     && req_ctrl_in != `DSPB_CTRL_SKIP;
  assign wr_ro     = accept && req_write_in && req_ctrl_in != `DSPB_CTRL_SKIP
                     && dspb_par_known(req_par_in) && req_par_in != `DSPB_PAR_POS;

  status_low_a: assert property (
    rd_status |=> rsp_valid_out && rsp_data_out[7:0] == $past(drive_status_flags[7:0])
      && $past(drive_status_flags[6]) == $past(drive_running_in, 2))
    else $error("status low byte answer wrong");
  status_high_a: assert property (
    rd_status |=> rsp_data_out[15:8] == $past(drive_status_flags[15:8])
      && $past(drive_status_flags[15]) == $past(negative_limit_in, 2)
      && rsp_data_out[31:16] == `DSPB_ZERO16)
    else $error("status high byte answer wrong");
  pos_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_POS)
      |=> rsp_data_out == $past(position_readback) && !rsp_error_out)
    else $error("position read answer wrong");
  // The reload lands at the answer edge; a step in the same cycle is lost
  pos_reload_a: assert property (
    (wr_pos && !drive_status_flags[`DSPB_RUN_BIT])
      |=> !rsp_error_out && position_readback == $past(req_wdata_in))
    else $error("standstill reload did not take");
  moving_reject_a: assert property (
    (wr_pos && drive_status_flags[6] && !pos_step_in)
      |=> rsp_error_out && position_readback == $past(position_readback))
    else $error("position written while moving");
  volt_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_ULOGIC)
      |=> rsp_data_out == {`DSPB_ZERO16, $past(logic_volt_in, 2)} && !rsp_error_out)
    else $error("control voltage answer wrong");
  ro_reject_a: assert property (
    wr_ro |=> rsp_valid_out && rsp_error_out && rsp_data_out == `DSPB_ZERO32)
    else $error("read-only write not refused");
  one_answer_a: assert property (
    accept |=> rsp_valid_out && !req_ready_out ##1 !rsp_valid_out && req_ready_out)
    else $error("answer not a single pulse");

  // ----------------------------------------
  // Further read answers
  // ----------------------------------------
  // Measurements pass one snapshot stage, so the answer carries the pin
  // value from two edges back; a direct path would skew multi-word reads
  umotor_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_UMOTOR)
      |=> rsp_data_out == {`DSPB_ZERO16, $past(motor_volt_in, 2)} && !rsp_error_out)
    else $error("motor voltage answer wrong");
  // Temperature and speed are signed, so the upper half repeats bit 15
  temp_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_TEMP)
      |=> rsp_data_out[15:0] == $past(temperature_in, 2)
      && rsp_data_out[31:16] == {16{$past(temperature_in[`DSPB_SIGN_BIT], 2)}})
    else $error("temperature answer wrong");
  node_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_NODE)
      |=> rsp_data_out == {`DSPB_ZERO16, $past(node_selector_in, 2)})
    else $error("selector answer wrong");
  date_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_DATE)
      |=> rsp_data_out == {`DSPB_ZERO16, MFG_YEAR_WEEK} && !rsp_error_out)
    else $error("manufacturing date answer wrong");
  peak_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_PEAK)
      |=> rsp_data_out == {`DSPB_ZERO16, $past(peak_torque_last_run)})
    else $error("peak torque answer wrong");
  // Speed and torque carry no unit rule but follow the same snapshot path
  torque_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_TORQUE)
      |=> rsp_data_out == {`DSPB_ZERO16, $past(torque_in, 2)})
    else $error("torque answer wrong");
  speed_read_a: assert property (
    (accept && !req_write_in && req_par_in == `DSPB_PAR_SPEED)
      |=> rsp_data_out[15:0] == $past(speed_in, 2)
      && rsp_data_out[31:16] == {16{$past(speed_in[`DSPB_SIGN_BIT], 2)}})
    else $error("speed answer wrong");

  // ----------------------------------------
  // Write and handshake corner cases
  // ----------------------------------------
  // A zero control byte drops a write to a known number without complaint, which lets a
  // controller replay a stored configuration without moving the reference
  skip_write_a: assert property (
    (accept && req_write_in && req_ctrl_in == `DSPB_CTRL_SKIP
      && dspb_par_known(req_par_in) && !pos_step_in)
      |=> !rsp_error_out && position_readback == $past(position_readback))
    else $error("dropped write had an effect");
  // Unknown numbers answer with an error and an all-zero word
  unknown_par_a: assert property (
    (accept && !dspb_par_known(req_par_in))
      |=> rsp_error_out && rsp_data_out == `DSPB_ZERO32)
    else $error("unknown parameter not refused");
  // Guards the first cycle after reset, when the sequencer is idle but ready is low
  busy_refuse_a: assert property (
    !req_ready_out |=> !rsp_valid_out)
    else $error("answer without a taken request");

  // ----------------------------------------
  // Scenario coverage
  // ----------------------------------------
  // Main transfers: status read, accepted and refused reloads, back-to-back, dropped write
  read_ok_c:    cover property (rd_status ##1 rsp_valid_out);
  reload_ok_c:  cover property (wr_pos ##1 (rsp_valid_out && !rsp_error_out));
  reject_run_c: cover property (wr_pos ##1 (rsp_valid_out && rsp_error_out));
  back2back_c:  cover property (accept ##2 accept);
  skip_wr_c:    cover property (accept && req_write_in && req_ctrl_in == `DSPB_CTRL_SKIP);
endmodule

// ===== dspb_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Parameter channel requester
// ----------------------------------------
module dspb_ctrl_model (
  input  wire logic        ref_clk_in,
  input  wire logic        req_ready_in,
  input  wire logic        rsp_valid_in,
  input  wire logic        rsp_error_in,
  input  wire logic [31:0] rsp_data_in,
  output logic             req_valid_out,
  output logic             req_write_out,
  output logic [7:0]       req_par_out,
  output logic [7:0]       req_ctrl_out,
  output logic [31:0]      req_wdata_out
);
  // Idle channel at time zero
  initial begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_par_out   = 8'h00;
    req_ctrl_out  = 8'h00;
    req_wdata_out = 32'h0000_0000;
  end

  // One transfer: held until taken, answer one edge later
  task automatic xfer(input logic wr, input logic [7:0] par, input logic [7:0] ctrl,
                      input logic [31:0] wd, output logic [31:0] rd, output logic err,
                      output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    req_valid_out <= 1'b1;
    req_write_out <= wr;
    req_par_out   <= par;
    req_ctrl_out  <= ctrl;
    req_wdata_out <= wd;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (req_ready_in !== 1'b1 && n < 20);
    // Released lines show garbage, so stale values cannot pass for fresh ones
    req_valid_out <= 1'b0;
    req_write_out <= ~wr;
    req_par_out   <= ~par;
    req_ctrl_out  <= ~ctrl;
    req_wdata_out <= ~wd;
    @(posedge ref_clk_in);
    ok  = (n < 20) && (rsp_valid_in === 1'b1);
    rd  = rsp_data_in;
    err = rsp_error_in;
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
  import dspb_pkg::*;
  // Arbitrary identity values
  localparam logic [15:0] MFG_DATE = 16'h2411;
  localparam logic [15:0] SERIAL   = 16'h1357;

  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [15:0] flags      = 16'h0000;
  dspb_word_t  meas [6]   = '{16'h8123, 16'h0457, 16'h00F0, 16'h01E0, 16'hFFF6, 16'h0021};
  logic        startup    = 1'b0;
  logic        braking    = 1'b0;
  logic        pos_step   = 1'b0;
  logic        pos_dir    = 1'b0;
  logic        valid, write, ready, rvalid, rerr;
  logic [7:0]  par, ctrl;
  logic [31:0] wdata, rdata, rd;
  logic        er;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  dspb_top #(.MFG_YEAR_WEEK(MFG_DATE), .UNIT_SERIAL(SERIAL)) dspb_top_i (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(valid), .req_write_in(write), .req_par_in(par),
    .req_ctrl_in(ctrl), .req_wdata_in(wdata),
    .req_ready_out(ready), .rsp_valid_out(rvalid), .rsp_error_out(rerr),
    .rsp_data_out(rdata),
    .target_reached_in(flags[0]), .drag_error_in(flags[1]),
    .jog_reverse_key_in(flags[2]), .jog_forward_key_in(flags[3]),
    .motor_power_in(flags[4]), .run_aborted_in(flags[5]),
    .drive_running_in(flags[6]), .over_temperature_in(flags[7]),
    .against_loop_in(flags[8]), .general_error_in(flags[9]),
    .blocked_error_in(flags[10]), .manual_displaced_in(flags[11]),
    .bad_target_in(flags[12]), .motor_power_lost_in(flags[13]),
    .positive_limit_in(flags[14]), .negative_limit_in(flags[15]),
    .speed_in(meas[0]), .torque_in(meas[1]), .logic_volt_in(meas[2]),
    .motor_volt_in(meas[3]), .temperature_in(meas[4]), .node_selector_in(meas[5]),
    .startup_phase_in(startup), .braking_phase_in(braking),
    .pos_step_in(pos_step), .pos_dir_in(pos_dir)
  );

  dspb_ctrl_model dspb_ctrl_model_i (
    .ref_clk_in(ref_clk_in), .req_ready_in(ready), .rsp_valid_in(rvalid),
    .rsp_error_in(rerr), .rsp_data_in(rdata), .req_valid_out(valid),
    .req_write_out(write), .req_par_out(par), .req_ctrl_out(ctrl), .req_wdata_out(wdata)
  );

  // 40 MHz clock
  always #12.5 ref_clk_in = ~ref_clk_in;

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic fail(input string msg);
    n_errors++;
    $display("mismatch %0t %s", $time, msg);
  endtask

  task automatic print_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] exp);
    n_compared++;
    if (rd !== exp) fail($sformatf("data %h expected %h", rd, exp));
  endtask

  task automatic chk_err(input logic exp);
    n_compared++;
    if (er !== exp) fail($sformatf("error flag %b expected %b", er, exp));
  endtask

  task automatic req(input logic wr, input logic [7:0] p, input logic [31:0] wd);
    logic ok;
    dspb_ctrl_model_i.xfer(wr, p, 8'h01, wd, rd, er, ok);
    if (ok !== 1'b1) fail("no answer");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_in);
      flags <= 16'h0001 << i;
      req(1'b0, 8'h01, 32'h0);
      chk_data({16'h0000, 16'h0001 << i});
    end
    flags <= 16'h0000;
  endtask

  task automatic t_meas;
    logic [7:0]  mp [6];
    logic [31:0] exp_w;
    mp = '{8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
    // Speed and temperature are signed, the rest zero-extended
    for (int i = 0; i < 6; i++) begin
      req(1'b0, mp[i], 32'h0);
      exp_w = (i == 0 || i == 4) ? {{16{meas[i][15]}}, meas[i]} : {16'h0000, meas[i]};
      chk_data(exp_w);
    end
    req(1'b0, 8'h0A, 32'h0);
    chk_data({16'h0000, MFG_DATE});
    req(1'b0, 8'h0B, 32'h0);
    chk_data({16'h0000, SERIAL});
  endtask

  task automatic t_readonly;
    for (int p = 1; p <= 11; p++) begin
      if (p != 3) begin
        req(1'b1, p[7:0], 32'h0000_5A5A);
        chk_err(1'b1);
      end
    end
    req(1'b0, 8'h0A, 32'h0);
    chk_data({16'h0000, MFG_DATE});
    req(1'b0, 8'h0C, 32'h0);
    chk_err(1'b1);
    chk_data(32'h0000_0000);
  endtask

  task automatic step(input logic dir, input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      pos_dir  <= dir;
      pos_step <= 1'b1;
      @(posedge ref_clk_in);
      pos_step <= 1'b0;
    end
  endtask

  task automatic t_pos;
    req(1'b0, 8'h03, 32'h0);
    chk_data(32'h0000_0000);
    step(1'b1, 5);
    step(1'b0, 7);
    req(1'b0, 8'h03, 32'h0);
    chk_data(32'hFFFF_FFFE);
    req(1'b1, 8'h03, 32'h0001_E240);
    chk_err(1'b0);
    req(1'b0, 8'h03, 32'h0);
    chk_data(32'h0001_E240);
    // Running blocks re-referencing
    flags[6] <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    req(1'b1, 8'h03, 32'h0000_1111);
    chk_err(1'b1);
    req(1'b0, 8'h03, 32'h0);
    chk_data(32'h0001_E240);
    flags[6] <= 1'b0;
  endtask

  // Control byte zero drops a position write without an error
  task automatic t_skip;
    logic ok;
    dspb_ctrl_model_i.xfer(1'b1, 8'h03, 8'h00, 32'h0000_2222, rd, er, ok);
    if (ok !== 1'b1) fail("no answer");
    chk_err(1'b0);
    req(1'b0, 8'h03, 32'h0);
    chk_data(32'h0001_E240);
  endtask

  task automatic t_peak;
    @(posedge ref_clk_in);
    flags[6] <= 1'b1;
    startup  <= 1'b1;
    meas[1]  <= 16'h0384;
    repeat (3) @(posedge ref_clk_in);
    startup <= 1'b0;
    meas[1] <= 16'h012C;
    @(posedge ref_clk_in);
    meas[1] <= 16'h01F4;
    @(posedge ref_clk_in);
    meas[1] <= 16'h00C8;
    @(posedge ref_clk_in);
    braking <= 1'b1;
    meas[1] <= 16'h0320;
    repeat (2) @(posedge ref_clk_in);
    flags[6] <= 1'b0;
    braking  <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    req(1'b0, 8'h05, 32'h0);
    chk_data(32'h0000_01F4);
    // A new run starts a fresh peak
    flags[6] <= 1'b1;
    meas[1]  <= 16'h0064;
    repeat (3) @(posedge ref_clk_in);
    flags[6] <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    req(1'b0, 8'h05, 32'h0);
    chk_data(32'h0000_0064);
  endtask

  // Hang guard
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      print_verdict;
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    t_pos;
    t_skip;
    t_status;
    t_meas;
    t_readonly;
    t_peak;
    print_verdict;
  end
endmodule
